// [core/fpec_pkg.sv]
// Package: register map, field layout, codes and timing for the flash program/erase sequencer
package fpec_pkg;
   // Register word offsets on the plain register port
   localparam logic [3:0] FPEC_OFS_CTRL = 4'h0; // flash_op_control
   localparam logic [3:0] FPEC_OFS_KEY = 4'h1; // unlock_key_reg, write only
   localparam logic [3:0] FPEC_OFS_TABLE_PAGE_REG = 4'h2; // table_page_reg
   localparam logic [3:0] FPEC_OFS_IRQ_STAT = 4'h3; // Sticky events, write one to clear
   localparam logic [3:0] FPEC_OFS_IRQ_MASK = 4'h4; // Event enables
   // Control register field positions
   localparam int FPEC_BIT_START = 15;
   localparam int FPEC_BIT_OP_WRITE_ENABLE = 14;
   localparam int FPEC_BIT_ERR = 13;
   localparam int FPEC_BIT_ERASE = 6;
   localparam int FPEC_OP_MSB = 3;
   // Reset values
   localparam logic [15:0] FPEC_CTRL_RST = 16'h0000;
   localparam logic [7:0] FPEC_TABLE_PAGE_REG_RST = 8'h00;
   localparam logic [1:0] FPEC_IRQ_RST = 2'h0;
   // Interrupt status bits
   localparam int FPEC_IRQ_DONE = 0;
   localparam int FPEC_IRQ_ERR = 1;
   // Unlock keys
   localparam logic [15:0] FPEC_KEY1 = 16'h0055;
   localparam logic [15:0] FPEC_KEY2 = 16'h00AA;
   // Operation select codes
   localparam logic [3:0] FPEC_OP_BULK = 4'hF;
   localparam logic [3:0] FPEC_OP_WORD = 4'h3;
   localparam logic [3:0] FPEC_OP_PAGE = 4'h2;
   localparam logic [3:0] FPEC_OP_ROW = 4'h1;
   // Geometry: 64 instructions per row, address steps by 2 per instruction
   localparam int FPEC_ROW_WORDS = 64;
   localparam logic [23:0] FPEC_ROW_MASK = 24'hFF_FF80; // 192-byte row boundary
   localparam logic [23:0] FPEC_PAGE_MASK = 24'hFF_FC00; // 1536-byte block boundary
   // Self-timed durations at 25 MHz
   localparam int FPEC_CLK_MHZ = 25;
   localparam int FPEC_ERASE_US = 2000;
   localparam int FPEC_ERASE_CYC = FPEC_ERASE_US * FPEC_CLK_MHZ;
   localparam int FPEC_WORD_US = 40;
   localparam int FPEC_WORD_CYC = FPEC_WORD_US * FPEC_CLK_MHZ;
   localparam int FPEC_CNT_W = 20;
   // Sequencer states
   typedef enum logic [1:0] {
      FPEC_ST_IDLE = 2'b00,
      FPEC_ST_ERASE = 2'b01,
      FPEC_ST_PROG = 2'b10
   } fpec_state_e;
   // Command toward the flash array
   typedef struct packed {
      logic prog; // Word write strobe level
      logic erase; // Erase level
      logic bulk; // Erase covers the whole memory
      logic [23:0] addr; // Target program address
      logic [23:0] data; // Instruction word
   } fpec_fa_cmd_s;
endpackage

// [core/fpec_sync.sv]
// Two flip-flop level synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module fpec_sync (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Power-on reset, async high
   input wire logic d_in, // Asynchronous level
   output logic q_out // Synchronised level
);
   logic meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_r <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [core/fpec_top.sv]
// Flash program/erase sequencer: unlock, control register, holding latches, self-timed array operations
//
// Operation
// - Keys 55h then AAh before any start
// - Core held stalled while operation runs
// - Start bit set by software, hardware clears
// - Write-enable zero inhibits program and erase
// - Error flag on improper sequence, clear otherwise
// - Erase-select picks erase or program meaning
// - Code 1111 bulk erase, external mode only
// - Code 0011 programs one word
// - Code 0010 erases one eight-row page
// - Code 0001 programs row from latches
// - Other codes start nothing
// - Control bits reset only by power-on
// - Table writes land in holding latches
// - Rows and blocks aligned to boundaries
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpec_top
   import fpec_pkg::*;
#(
   parameter int ERASE_CYC = FPEC_ERASE_CYC, // Erase duration in clocks
   parameter int WORD_CYC = FPEC_WORD_CYC // Per-word program duration in clocks
) (
   input wire logic sys_clk, // System clock, 25 MHz
   input wire logic rst, // Power-on reset, async high
   input wire logic soft_rst, // Other reset sources, sync high
   input wire logic ext_prog_pin, // External serial programming mode pin
   input wire logic [3:0] reg_addr, // Register word offset
   input wire logic [15:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [15:0] reg_rdata, // Read data, cycle after strobe
   input wire logic tbl_wr, // Table write strobe
   input wire logic [15:0] tbl_ofs, // Table write effective address
   input wire logic [23:0] tbl_data, // Table write instruction word
   output logic cpu_stall, // Core stall while busy
   output logic irq, // Level interrupt
   output fpec_fa_cmd_s fa_cmd // Command toward the flash array
);
   fpec_state_e state_r;
   logic ext_mode;
   logic op_write_enable_r, err_r, erase_r;
   logic [3:0] op_r;
   logic [7:0] table_page_reg_r;
   logic [23:0] tgt_addr_r;
   logic key1_r, armed_r;
   logic [1:0] irq_stat_r, irq_mask_r;
   logic [23:0] latch_mem [FPEC_ROW_WORDS];
   logic [FPEC_CNT_W-1:0] cnt_r;
   logic [5:0] widx_r;
   logic row_mode_r;
   logic ctrl_wr, key_wr, start_try, op_valid, start_ok, seq_err_ev, done_ev;
   logic [5:0] tbl_idx;
   logic [23:0] ctrl_word;

   // Pin crosses into the clock domain before use
   fpec_sync u_mode_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d_in(ext_prog_pin),
      .q_out(ext_mode)
   );

   // Request decode; control writes are ignored while busy since the core is stalled then
   always_comb begin
      ctrl_wr = reg_wr && (reg_addr == FPEC_OFS_CTRL) && (state_r == FPEC_ST_IDLE);
      key_wr = reg_wr && (reg_addr == FPEC_OFS_KEY);
      start_try = ctrl_wr && reg_wdata[FPEC_BIT_START];
      tbl_idx = tbl_ofs[6:1];
      ctrl_word = {8'h00, reg_wdata};
   end

   // Legal code and erase-select pairs; everything else is a no-op
   always_comb begin
      op_valid = 1'b0;
      if (reg_wdata[FPEC_BIT_ERASE]) begin
         op_valid = (reg_wdata[FPEC_OP_MSB:0] == FPEC_OP_PAGE)
            || ((reg_wdata[FPEC_OP_MSB:0] == FPEC_OP_BULK) && ext_mode);
      end else begin
         op_valid = (reg_wdata[FPEC_OP_MSB:0] == FPEC_OP_WORD)
            || (reg_wdata[FPEC_OP_MSB:0] == FPEC_OP_ROW);
      end
   end

   // Start needs unlock and write enable in the same write that sets the start bit
   always_comb begin
      start_ok = start_try && armed_r && reg_wdata[FPEC_BIT_OP_WRITE_ENABLE] && op_valid;
      seq_err_ev = start_try && !(armed_r && reg_wdata[FPEC_BIT_OP_WRITE_ENABLE]);
   end

   // Unlock tracker: any write between the two keys or after them breaks the sequence
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         key1_r <= 1'b0;
         armed_r <= 1'b0;
      end else if (soft_rst) begin
         key1_r <= 1'b0;
         armed_r <= 1'b0;
      end else if (reg_wr || tbl_wr) begin
         key1_r <= key_wr && (reg_wdata == FPEC_KEY1);
         armed_r <= key_wr && key1_r && (reg_wdata == FPEC_KEY2);
      end
   end

   // Control fields; only power-on reset returns them to zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         op_write_enable_r <= FPEC_CTRL_RST[FPEC_BIT_OP_WRITE_ENABLE];
         erase_r <= FPEC_CTRL_RST[FPEC_BIT_ERASE];
         op_r <= FPEC_CTRL_RST[FPEC_OP_MSB:0];
      end else if (ctrl_wr) begin
         op_write_enable_r <= reg_wdata[FPEC_BIT_OP_WRITE_ENABLE];
         erase_r <= reg_wdata[FPEC_BIT_ERASE];
         op_r <= reg_wdata[FPEC_OP_MSB:0];
      end
   end

   // Error flag: hardware set wins over a software write in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err_r <= FPEC_CTRL_RST[FPEC_BIT_ERR];
      end else if (seq_err_ev) begin
         err_r <= 1'b1;
      end else if (start_ok) begin
         err_r <= 1'b0;
      end else if (ctrl_wr) begin
         err_r <= reg_wdata[FPEC_BIT_ERR];
      end
   end

   // Table page register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         table_page_reg_r <= FPEC_TABLE_PAGE_REG_RST;
      end else if (reg_wr && (reg_addr == FPEC_OFS_TABLE_PAGE_REG)) begin
         table_page_reg_r <= reg_wdata[7:0];
      end
   end

   // Holding latches; no reset, contents are undefined until loaded
   always_ff @(posedge sys_clk) begin
      if (tbl_wr) begin
         latch_mem[tbl_idx] <= tbl_data;
      end
   end

   // Last table address is the target, including the dummy write before an erase
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tgt_addr_r <= 24'h00_0000;
      end else if (tbl_wr) begin
         tgt_addr_r <= {table_page_reg_r, tbl_ofs};
      end
   end

   // Self-timed sequencer; row and word program share the per-word step
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= FPEC_ST_IDLE;
         cnt_r <= '0;
         widx_r <= 6'h00;
         row_mode_r <= 1'b0;
      end else begin
         case (state_r)
            FPEC_ST_IDLE: begin
               if (start_ok && reg_wdata[FPEC_BIT_ERASE]) begin
                  state_r <= FPEC_ST_ERASE;
                  cnt_r <= FPEC_CNT_W'(ERASE_CYC - 1);
               end else if (start_ok) begin
                  state_r <= FPEC_ST_PROG;
                  cnt_r <= FPEC_CNT_W'(WORD_CYC - 1);
                  row_mode_r <= (reg_wdata[FPEC_OP_MSB:0] == FPEC_OP_ROW);
                  widx_r <= (reg_wdata[FPEC_OP_MSB:0] == FPEC_OP_ROW) ? 6'h00 : tgt_addr_r[6:1];
               end
            end
            FPEC_ST_ERASE: begin
               if (cnt_r == '0) begin
                  state_r <= FPEC_ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            FPEC_ST_PROG: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (row_mode_r && (widx_r != 6'h3F)) begin
                  widx_r <= widx_r + 1'b1;
                  cnt_r <= FPEC_CNT_W'(WORD_CYC - 1);
               end else begin
                  state_r <= FPEC_ST_IDLE;
               end
            end
            default: begin
               state_r <= FPEC_ST_IDLE;
            end
         endcase
      end
   end

   // Completion is the last cycle of either busy state
   always_comb begin
      done_ev = (cnt_r == '0) && ((state_r == FPEC_ST_ERASE)
         || ((state_r == FPEC_ST_PROG) && !(row_mode_r && (widx_r != 6'h3F))));
   end

   // Stall follows the busy state; lags start by one edge, covered by the two no-ops
   // It also stays up through the done cycle, so the registered array command never outlives it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= start_ok || (state_r != FPEC_ST_IDLE);
      end
   end

   // Array command, aligned to row or block boundaries
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fa_cmd <= '0;
      end else begin
         fa_cmd.erase <= (state_r == FPEC_ST_ERASE) && !done_ev;
         fa_cmd.bulk <= (state_r == FPEC_ST_ERASE) && (op_r == FPEC_OP_BULK);
         fa_cmd.prog <= (state_r == FPEC_ST_PROG) && op_write_enable_r;
         fa_cmd.data <= latch_mem[widx_r];
         if (state_r == FPEC_ST_ERASE) begin
            fa_cmd.addr <= (op_r == FPEC_OP_BULK) ? 24'h00_0000 : (tgt_addr_r & FPEC_PAGE_MASK);
         end else begin
            fa_cmd.addr <= (tgt_addr_r & FPEC_ROW_MASK) | {17'h0_0000, widx_r, 1'b0};
         end
      end
   end

   // Sticky events; a new event wins over a clearing write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= FPEC_IRQ_RST;
         irq_mask_r <= FPEC_IRQ_RST;
      end else begin
         if (reg_wr && (reg_addr == FPEC_OFS_IRQ_MASK)) begin
            irq_mask_r <= reg_wdata[1:0];
         end
         irq_stat_r[FPEC_IRQ_DONE] <= done_ev
            || (irq_stat_r[FPEC_IRQ_DONE] && !(reg_wr && (reg_addr == FPEC_OFS_IRQ_STAT)
            && reg_wdata[FPEC_IRQ_DONE]));
         irq_stat_r[FPEC_IRQ_ERR] <= seq_err_ev
            || (irq_stat_r[FPEC_IRQ_ERR] && !(reg_wr && (reg_addr == FPEC_OFS_IRQ_STAT)
            && reg_wdata[FPEC_IRQ_ERR]));
      end
   end

   // Interrupt level registered from status and mask
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // Read data for one cycle after the strobe; key and unmapped offsets read zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            FPEC_OFS_CTRL: reg_rdata <= {(state_r != FPEC_ST_IDLE), op_write_enable_r, err_r, 6'h00,
               erase_r, 2'h0, op_r};
            FPEC_OFS_TABLE_PAGE_REG: reg_rdata <= {8'h00, table_page_reg_r};
            FPEC_OFS_IRQ_STAT: reg_rdata <= {14'h0000, irq_stat_r};
            FPEC_OFS_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask_r};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Spare bits of the decode word are unused by design
   logic unused_ok;
   assign unused_ok = &{1'b0, ctrl_word[23:16]};
endmodule
`default_nettype wire

// [tb/flash_program_erase_control_bench.sv]
// Testbench for the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_bench
   import fpec_pkg::*;
;
   localparam int EC = 20;
   localparam int WC = 4;
   logic sys_clk, rst, soft_rst, ext_prog_pin, reg_wr, reg_rd, tbl_wr, cpu_stall, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, tbl_ofs;
   logic [23:0] tbl_data;
   fpec_fa_cmd_s fa_cmd;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int p, i;
   logic [15:0] nop [6] = '{16'hC041, 16'hC043, 16'hC002, 16'hC00F, 16'hC004, 16'hC04F};
   fpec_top #(.ERASE_CYC(EC), .WORD_CYC(WC)) u_dut (.sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst),
      .ext_prog_pin(ext_prog_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tbl_wr(tbl_wr), .tbl_ofs(tbl_ofs), .tbl_data(tbl_data), .cpu_stall(cpu_stall),
      .irq(irq), .fa_cmd(fa_cmd));
   fpec_flash_model u_fm (.sys_clk(sys_clk), .rst(rst), .fa_cmd(fa_cmd));
   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic wrap_up();
      if (fail_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Hang guard, far above the longest run
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bus tasks leave an idle cycle so no strobe is driven twice in one step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk) reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
      @(posedge sys_clk);
   endtask
   task automatic tw(input logic [15:0] o, input logic [23:0] d);
      tbl_ofs <= o;
      tbl_data <= d;
      tbl_wr <= 1'b1;
      @(posedge sys_clk) tbl_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Full unlock then start; caller waits after it as a pair of no-ops would
   task automatic go(input logic [15:0] c);
      wr(FPEC_OFS_KEY, FPEC_KEY1);
      wr(FPEC_OFS_KEY, FPEC_KEY2);
      wr(FPEC_OFS_CTRL, c);
      #1;
   endtask
   task automatic wait_idle();
      chk("cpu_stall", 24'h00_0001, {23'h0, cpu_stall});
      for (int k = 0; k < 2000 && cpu_stall !== 1'b0; k++) @(posedge sys_clk);
      @(posedge sys_clk);
   endtask
   initial begin
      {rst, soft_rst, ext_prog_pin, reg_wr, reg_rd, tbl_wr} = 6'b10_0000;
      {reg_addr, reg_wdata, tbl_ofs, tbl_data} = '0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (i = 0; i < 16; i++) rd(4'(i), 16'h0000);
      wr(FPEC_OFS_IRQ_MASK, 16'h0003);
      // Start without any unlock
      wr(FPEC_OFS_CTRL, 16'hC003);
      rd(FPEC_OFS_CTRL, 16'h6003);
      chk("irq", 24'h00_0001, {23'h0, irq});
      wr(FPEC_OFS_IRQ_STAT, 16'h0002);
      rd(FPEC_OFS_IRQ_STAT, 16'h0000);
      chk("irq", 24'h00_0000, {23'h0, irq});
      // Keys split by another write
      wr(FPEC_OFS_KEY, FPEC_KEY1);
      wr(FPEC_OFS_TABLE_PAGE_REG, 16'h0001);
      wr(FPEC_OFS_KEY, FPEC_KEY2);
      wr(FPEC_OFS_CTRL, 16'hC003);
      rd(FPEC_OFS_CTRL, 16'h6003);
      go(16'h8003);
      rd(FPEC_OFS_CTRL, 16'h2003);
      // Codes that mean nothing for their erase-select, are unimplemented, or bulk erase outside external mode
      for (i = 0; i < 6; i++) begin
         go(nop[i]);
         chk("cpu_stall", 24'h00_0000, {23'h0, cpu_stall});
      end
      chk("prog_cyc", 24'h00_0000, 24'(u_fm.prog_cyc));
      wr(FPEC_OFS_IRQ_STAT, 16'h0003);
      // Single word
      tw(16'h1234, 24'hAB_CDEF);
      go(16'hC003);
      wait_idle();
      chk("last_addr", 24'h01_1234, u_fm.last_addr);
      chk("last_data", 24'hAB_CDEF, u_fm.last_data);
      chk("prog_cyc", 24'(WC), 24'(u_fm.prog_cyc));
      rd(FPEC_OFS_CTRL, 16'h4003);
      rd(FPEC_OFS_IRQ_STAT, 16'h0001);
      chk("irq", 24'h00_0001, {23'h0, irq});
      // Full row from latches
      wr(FPEC_OFS_TABLE_PAGE_REG, 16'h0000);
      for (i = 0; i < 64; i++) tw(16'h0100 + 16'(i * 2), 24'h10_0000 + 24'(i));
      p = u_fm.prog_cyc;
      go(16'hC001);
      wait_idle();
      for (i = 0; i < 64; i++) chk("row_word", 24'h10_0000 + 24'(i), u_fm.mem[i]);
      chk("row_cyc", 24'(64 * WC), 24'(u_fm.prog_cyc - p));
      chk("row_base", 24'h00_0100, u_fm.last_addr & FPEC_ROW_MASK);
      // Page erase after a dummy table write sets its address
      wr(FPEC_OFS_TABLE_PAGE_REG, 16'h0002);
      tw(16'h0C40, 24'h00_0000);
      go(16'hC042);
      wait_idle();
      chk("erase_addr", 24'h02_0C00, u_fm.erase_addr & FPEC_PAGE_MASK);
      chk("bulk_seen", 24'h00_0000, {23'h0, u_fm.bulk_seen});
      // Bulk erase in external mode
      ext_prog_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      go(16'hC04F);
      wait_idle();
      chk("bulk_seen", 24'h00_0001, {23'h0, u_fm.bulk_seen});
      ext_prog_pin <= 1'b0;
      // Other reset drops the unlock but keeps control bits
      wr(FPEC_OFS_KEY, FPEC_KEY1);
      soft_rst <= 1'b1;
      @(posedge sys_clk) soft_rst <= 1'b0;
      @(posedge sys_clk);
      wr(FPEC_OFS_KEY, FPEC_KEY2);
      wr(FPEC_OFS_CTRL, 16'hC003);
      rd(FPEC_OFS_CTRL, 16'h6003);
      soft_rst <= 1'b1;
      @(posedge sys_clk) soft_rst <= 1'b0;
      @(posedge sys_clk);
      rd(FPEC_OFS_CTRL, 16'h6003);
      wrap_up();
   end
endmodule
`default_nettype wire

// [tb/fpec_flash_model.sv]
// Flash array model recording what the sequencer commits
`timescale 1ns/1ps
`default_nettype none
module fpec_flash_model
   import fpec_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic rst, // Power-on reset
   input wire fpec_fa_cmd_s fa_cmd // Command from sequencer
);
   logic [23:0] mem [0:63]; // One row, indexed by word within row
   logic [23:0] last_addr, last_data, erase_addr;
   logic bulk_seen;
   int prog_cyc;
   // Commit latch data only while programming; counts program cycles to time each program op
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prog_cyc <= 0;
         bulk_seen <= 1'b0;
      end else begin
         if (fa_cmd.prog) begin
            mem[fa_cmd.addr[6:1]] <= fa_cmd.data;
            last_addr <= fa_cmd.addr;
            last_data <= fa_cmd.data;
            prog_cyc <= prog_cyc + 1;
         end
         if (fa_cmd.erase) begin
            erase_addr <= fa_cmd.addr;
            bulk_seen <= bulk_seen | fa_cmd.bulk;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/fpec_top_asserts.sv]
// Port checker for the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module fpec_top_asserts
   import fpec_pkg::*;
#(
   parameter int ERASE_CYC = 20, // Erase length in clocks
   parameter int WORD_CYC = 4 // Word length in clocks
) (
   input wire logic sys_clk, // Clock
   input wire logic rst, // Power-on reset
   input wire logic ext_prog_pin, // External mode pin
   input wire logic [3:0] reg_addr, // Register offset
   input wire logic [15:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [15:0] reg_rdata, // Read data
   input wire logic cpu_stall, // Core stall
   input wire fpec_fa_cmd_s fa_cmd // Array command
);
   logic [19:0] er_cnt_r; // Cycles the erase level has stood
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Erase length counter, cleared whenever erase is low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) er_cnt_r <= 20'h0_0000;
      else er_cnt_r <= fa_cmd.erase ? er_cnt_r + 20'h0_0001 : 20'h0_0000;
   end
   property p_start_src;
      $rose(cpu_stall) |-> $past(reg_wr && reg_addr == FPEC_OFS_CTRL && reg_wdata[FPEC_BIT_START]
         && reg_wdata[FPEC_BIT_OP_WRITE_ENABLE]);
   endproperty
   a_start_src: assert property (p_start_src) else $error("stall rose without enabled start");
   property p_no_op_write_enable;
      reg_wr && reg_addr == FPEC_OFS_CTRL && !reg_wdata[FPEC_BIT_OP_WRITE_ENABLE] && !cpu_stall |=> !cpu_stall;
   endproperty
   a_no_op_write_enable: assert property (p_no_op_write_enable) else $error("start taken with write enable low");
   property p_cmd_next;
      $rose(cpu_stall) |=> fa_cmd.prog || fa_cmd.erase;
   endproperty
   a_cmd_next: assert property (p_cmd_next) else $error("no array command after stall");
   property p_stall_cov;
      fa_cmd.prog || fa_cmd.erase |-> cpu_stall;
   endproperty
   a_stall_cov: assert property (p_stall_cov) else $error("array busy while core runs");
   property p_excl;
      !(fa_cmd.prog && fa_cmd.erase);
   endproperty
   a_excl: assert property (p_excl) else $error("program and erase together");
   property p_bulk_pin;
      fa_cmd.erase && fa_cmd.bulk |-> ext_prog_pin;
   endproperty
   a_bulk_pin: assert property (p_bulk_pin) else $error("bulk erase outside external mode");
   property p_erase_len;
      $fell(fa_cmd.erase) |-> er_cnt_r == 20'(ERASE_CYC - 1);
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   property p_key_rd;
      $past(reg_rd && reg_addr == FPEC_OFS_KEY) |-> reg_rdata == 16'h0000;
   endproperty
   a_key_rd: assert property (p_key_rd) else $error("key register readable");
endmodule
bind fpec_top fpec_top_asserts #(.ERASE_CYC(ERASE_CYC), .WORD_CYC(WORD_CYC)) u_chk (.sys_clk(sys_clk),
   .rst(rst), .ext_prog_pin(ext_prog_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .fa_cmd(fa_cmd));
`default_nettype wire
